// *** bench/oacc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oacc_map.vh"
module oacc_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Clock control outputs
  input wire logic [2:0]  current_source_sel,
  input wire logic        aux_pll_enable,
  input wire logic        aux_pll_ref_primary,
  input wire logic        aux_pll_ref_fast_rc,
  input wire logic        aux_ref_primary,
  input wire logic [31:0] pin_map
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Writes taken in the address phase; data lands one edge later
  wire wr_take = hsel && hready && htrans[1] && hwrite;
  wire wr_aclk = wr_take && (haddr == `OACC_OFS_ACLK);
  wire wr_pps  = wr_take && (haddr == `OACC_OFS_PPS0 || haddr == `OACC_OFS_PPS1);
  a_zero_wait: assert property (hreadyout == 1'b1) else $error("ready low");
  a_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper half set");
  a_no_reserved: assert property (current_source_sel != `OACC_SRC_RSVD) else $error("reserved src");
  a_switch_settles: assert property ($changed(current_source_sel) |=> $stable(current_source_sel) [*8])
    else $error("source bounces");
  a_auxen_by_write: assert property ($rose(aux_pll_enable) |-> $past(wr_aclk, 2) && $past(hwdata[15]))
    else $error("aux enable rose unasked");
  // Pin-level copies sit one register behind the control bits
  a_ref_by_write: assert property ($changed(aux_ref_primary) |-> $past(wr_aclk, 3)
    && aux_ref_primary == $past(hwdata[7], 2)) else $error("aux ref changed unasked");
  a_primary_path: assert property (aux_pll_ref_primary == (aux_ref_primary && !aux_pll_ref_fast_rc))
    else $error("pll input path wrong");
  a_frc_by_write: assert property ($changed(aux_pll_ref_fast_rc) |-> $past(wr_aclk, 3))
    else $error("fast rc select unasked");
  a_pins_by_write: assert property ($changed(pin_map) |-> $past(wr_pps, 3))
    else $error("pin map changed unasked");
endmodule
bind oacc_top oacc_props oacc_props_i (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .current_source_sel(current_source_sel),
  .aux_pll_enable(aux_pll_enable), .aux_pll_ref_primary(aux_pll_ref_primary),
  .aux_pll_ref_fast_rc(aux_pll_ref_fast_rc), .aux_ref_primary(aux_ref_primary), .pin_map(pin_map));
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oacc_map.vh"
module tb;
  // Stimulus
  logic        mclk = 0, reset_n = 0, sys_reset_n = 1, hsel = 0, hwrite = 0, rd_ph = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0, mon_cfg = 0;
  logic [31:0] hwdata = 0, d, v;
  logic        pll_lk = 0, aux_lk = 0, cfail = 0, osc_tk = 1, vco_tk = 0;
  // Observed
  wire  [31:0] hrdata, pin_map;
  wire  [2:0]  cur;
  wire         hreadyout, hresp, aux_en, ref_pri, ref_frc, aux_ref, tick, irq;
  logic [63:0] exp_q[$];
  logic [63:0] m;
  integer      errors = 0, cmp_count = 0, cyc = 0, seed = 32'hf013, n, i;
  oacc_top oacc_top_i (.mclk(mclk), .reset_n(reset_n), .sys_reset_n(sys_reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .por_source_sel(3'h0),
    .switch_monitor_config(mon_cfg), .pll_locked_in(pll_lk), .aux_pll_lock_in(aux_lk),
    .clock_fail_in(cfail), .aux_osc_tick(osc_tk), .pll_vco_tick(vco_tk), .current_source_sel(cur),
    .aux_pll_enable(aux_en), .aux_pll_ref_primary(ref_pri), .aux_pll_ref_fast_rc(ref_frc),
    .aux_ref_primary(aux_ref), .aux_clk_tick(tick), .pin_map(pin_map), .irq(irq));
  always #2.5 mclk = ~mclk;
  task automatic check(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the 1500 or so cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // Read results: oldest note against data seen at the data-phase edge
  always @(posedge mclk) if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
    m = exp_q.pop_front();
    check(hrdata & m[63:32], m[31:0]);
  end
  // Single AHB transfer, held until ready is seen
  task automatic bus(input [11:0] a, input logic w, input [31:0] wd);
    @(posedge mclk);
    hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd; rd_ph <= !w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd_ph <= 0;
  endtask
  task automatic wr(input [11:0] a, input [31:0] wd); bus(a, 1, wd); endtask
  task automatic rd(input [11:0] a, input [31:0] e, input [31:0] mk);
    exp_q.push_back({mk, e & mk});
    bus(a, 0, 0);
  endtask
  task automatic unlk; wr(`OACC_OFS_UNLOCK, `OACC_UNLOCK_KEY1); wr(`OACC_OFS_UNLOCK, `OACC_UNLOCK_KEY2); endtask
  task automatic pause(input integer k); repeat (k) @(posedge mclk); #1; endtask
  // Cycles up to the next divided tick
  task automatic gap(output integer g);
    g = 0;
    do begin @(posedge mclk); #1; g++; end while (tick !== 1'b1 && g < 600);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1;
    repeat (2) @(posedge mclk);
    rd(`OACC_OFS_ACLK, 32'h2700, 32'hffff);
    rd(`OACC_OFS_OSC, 32'h0000, 32'hffff);
    rd(12'h020, 0, 32'hffffffff);
    wr(`OACC_OFS_OSC, 32'h0101); pause(30); rd(`OACC_OFS_OSC, 0, 32'hffff);
    pll_lk <= 1;
    unlk; wr(`OACC_OFS_OSC, 32'h0101); pause(60); check(cur, 1);
    rd(`OACC_OFS_OSC, 32'h1120, 32'h7729);
    rd(`OACC_OFS_STAT, 1, 1);
    // Interrupt raised, masked, cleared
    wr(`OACC_OFS_IEN, 1); pause(2); check(irq, 1);
    wr(`OACC_OFS_IEN, 0); pause(2); check(irq, 0);
    wr(`OACC_OFS_ICLR, 7); wr(`OACC_OFS_IEN, 2);
    cfail <= 1; @(posedge mclk); cfail <= 0; pause(3); check(irq, 1);
    rd(`OACC_OFS_STAT, 2, 2); wr(`OACC_OFS_ICLR, 2); pause(2); check(irq, 0);
    unlk; wr(`OACC_OFS_OSC, 32'h0400); rd(`OACC_OFS_OSC, 32'h0100, 32'h0700);
    // Frozen source must not move to plain fast RC
    mon_cfg <= 1; unlk; wr(`OACC_OFS_OSC, 32'h0180);
    unlk; wr(`OACC_OFS_OSC, 32'h0081); pause(40); check(cur, 1);
    d = $random(seed) & 32'h3f3f; wr(`OACC_OFS_PPS0, d); pause(2); check(pin_map, d);
    unlk; wr(`OACC_OFS_OSC, 32'h00c0); wr(`OACC_OFS_PPS1, 32'h1515); pause(2); check(pin_map, d);
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 32'ha7c0; aux_lk <= i[0]; wr(`OACC_OFS_ACLK, v); pause(2);
      check({aux_en, ref_pri, ref_frc, aux_ref}, {v[15], v[7] & !v[6], v[6], v[7]});
      rd(`OACC_OFS_ACLK, v | (i[0] << 14), 32'hffff);
    end
    // Other resets leave both registers alone
    sys_reset_n <= 0; pause(3); sys_reset_n <= 1;
    rd(`OACC_OFS_ACLK, v | 32'h4000, 32'hffff); rd(`OACC_OFS_OSC, 32'h00c0, 32'h00c0);
    for (i = 0; i < 8; i++) begin
      wr(`OACC_OFS_ACLK, 32'h2000 | (i << 8)); repeat (3) gap(n);
      check(n, i == 0 ? 256 : 1 << (7 - i));
    end
    osc_tk <= 0; vco_tk <= 1; wr(`OACC_OFS_ACLK, 32'h0700); repeat (3) gap(n); check(n, 1);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** hw/oacc_aux_divider.v ***
`timescale 1ns/1ps
`default_nettype none
`include "oacc_map.vh"
module oacc_aux_divider (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // Configuration
  input  wire [2:0] div_code,
  input  wire       clk_in,
  // Divided enable pulse
  output reg        clk_out
);
  reg  [`OACC_DIV_W-1:0] count;
  reg  [`OACC_DIV_W-1:0] limit;
  // Divider ratio decode, terminal count is ratio minus one
  always @* begin
    case (div_code)
      3'h7: limit = 8'h00; // [R9]
      3'h6: limit = 8'h01;
      3'h5: limit = 8'h03;
      3'h4: limit = 8'h07;
      3'h3: limit = 8'h0f;
      3'h2: limit = 8'h1f;
      3'h1: limit = 8'h3f;
      default: limit = 8'hff;
    endcase
  end
  // Counts input ticks; one output tick per ratio
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count   <= 8'h00;
      clk_out <= 1'b0;
    end else begin
      clk_out <= 1'b0;
      if (clk_in) begin
        if (count >= limit) begin
          count   <= 8'h00;
          clk_out <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/oacc_map.vh ***
// Functional notes
// [R1] Current and requested clock source are 3-bit codes; current is read-only; 100 reserved.
// [R2] With monitor config 01, freeze bit set blocks clock switching; clear allows it.
// [R3] Pin-select guard set makes pin-select mapping writes ignored; clear lets them land.
// [R4] PLL lock bit reads 1 when locked or start-up timer expired, else 0.
// [R5] Software never switches directly between primary-with-PLL and fast-RC-with-PLL.
// [R6] Both control registers reset only on power-on reset, not on other resets.
// [R7] Aux PLL enable resets to 0; aux PLL lock bit reads 1 only in lock.
// [R8] Aux divider source select: 1 aux oscillator path (reset), 0 primary PLL VCO.
// [R9] Aux output divider codes 111..001 divide 1..64 by powers of two, 000 by 256.
// [R10] Aux reference bit 1 selects primary oscillator; 0 selects no reference.
// [R11] Aux PLL input bit 1 uses fast RC; 0 follows the aux reference bit.
// [R12] Software keeps aux output divider at divide-by-1 whenever PWM is used.
// [R13] Oscillator control writes need an unlock sequence; switch bit clears on completion.
`ifndef OACC_MAP_VH
`define OACC_MAP_VH
`define OACC_OFS_OSC      12'h000
`define OACC_OFS_ACLK     12'h004
`define OACC_OFS_PPS0     12'h008
`define OACC_OFS_PPS1     12'h00c
`define OACC_OFS_UNLOCK   12'h010
`define OACC_OFS_STAT     12'h014
`define OACC_OFS_IEN      12'h018
`define OACC_OFS_ICLR     12'h01c
`define OACC_UNLOCK_KEY1  16'h0046
`define OACC_UNLOCK_KEY2  16'h0057
`define OACC_SRC_FRC      3'h0
`define OACC_SRC_FAST_RC_WITH_PLL   3'h1
`define OACC_SRC_PRI      3'h2
`define OACC_SRC_PRIPLL   3'h3
`define OACC_SRC_RSVD     3'h4
`define OACC_SRC_LOW_POWER_RC_OSCILLATOR     3'h5
`define OACC_MON_SW_ONLY  2'h1
`define OACC_ACLK_RESET   16'h2700
`define OACC_PPS_MASK     16'h3f3f
`define OACC_SWITCH_NS    100
`define OACC_SWITCH_CYC   ((`OACC_SWITCH_NS + 4) / 5)
`define OACC_PLL_START_NS 200
`define OACC_PLL_START_CYC ((`OACC_PLL_START_NS + 4) / 5)
`define OACC_DIV_W        8
`endif

// *** hw/oacc_pll_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "oacc_map.vh"
module oacc_pll_timer (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // Control
  input  wire       enable,
  input  wire       pll_locked_in,
  // Status
  output reg        lock_status
);
  reg [7:0] count;
  // Start-up timer restarts whenever the PLL is off
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count       <= 8'h00;
      lock_status <= 1'b0;
    end else if (!enable) begin
      count       <= 8'h00;
      lock_status <= 1'b0;
    end else begin
      if (count != `OACC_PLL_START_CYC)
        count <= count + 8'h01;
      lock_status <= pll_locked_in || (count == `OACC_PLL_START_CYC); // [R4]
    end
  end
endmodule
`default_nettype wire

// *** hw/oacc_top.v ***
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "oacc_map.vh"
module oacc_top (
  // Clock and power-on reset
  input  wire        mclk,
  input  wire        reset_n,
  // Other reset sources, do not touch control registers
  input  wire        sys_reset_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Power-on configuration
  input  wire [2:0]  por_source_sel,
  input  wire [1:0]  switch_monitor_config,
  // Analog status
  input  wire        pll_locked_in,
  input  wire        aux_pll_lock_in,
  input  wire        clock_fail_in,
  input  wire        aux_osc_tick,
  input  wire        pll_vco_tick,
  // Clock control outputs
  output reg  [2:0]  current_source_sel,
  output reg         aux_pll_enable,
  output reg         aux_pll_ref_primary,
  output reg         aux_pll_ref_fast_rc,
  output reg         aux_ref_primary,
  output reg         aux_clk_tick,
  output reg  [31:0] pin_map,
  // Interrupt
  output reg         irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SWITCH = 1'b1;

  reg        wr_pend;
  reg        rd_pend;
  reg [11:0] addr_q;
  reg        state;
  reg [7:0]  sw_count;
  reg [1:0]  unlock_stage;
  reg        por_seen;
  // Oscillator control fields
  reg [2:0]  requested_source_sel;
  reg        switch_freeze_bit;
  reg        pin_select_write_guard;
  reg        clock_fail_flag;
  reg        switch_request_bit;
  // Auxiliary control fields and pin-select mapping words
  reg        aux_divider_source_sel;
  reg [2:0]  aux_output_divider;
  reg        aux_reference_sel;
  reg        aux_pll_input_sel;
  reg [15:0] pps0;
  reg [15:0] pps1;
  // Events: bit0 switch done, bit1 clock fail, bit2 pll lock
  reg [2:0]  int_status;
  reg [2:0]  int_enable;
  reg        pll_lock_q;
  wire       pll_lock_status;
  wire       div_tick;
  wire       ahb_go;
  wire       do_wr;
  wire       freeze_active;
  wire       osc_unlocked;
  wire [2:0] ev;
  wire [15:0] osc_word;
  wire [15:0] aclk_word;

  assign ahb_go = hsel && hready && htrans[1];
  assign do_wr = wr_pend;
  assign freeze_active = switch_freeze_bit && (switch_monitor_config == `OACC_MON_SW_ONLY); // [R2]
  assign osc_unlocked = (unlock_stage == 2'h2);
  assign osc_word = {1'b0, current_source_sel, 1'b0, requested_source_sel, // [R1]
                     switch_freeze_bit, pin_select_write_guard, pll_lock_status,
                     1'b0, clock_fail_flag, 2'b00, switch_request_bit};
  assign aclk_word = {aux_pll_enable, aux_pll_lock_in, aux_divider_source_sel, // [R7]
                      2'b00, aux_output_divider, aux_reference_sel, aux_pll_input_sel, 6'h00};

  // PLL start-up timer and lock status
  oacc_pll_timer u_timer (
    .mclk          (mclk),
    .reset_n       (reset_n),
    .enable        (current_source_sel == `OACC_SRC_FAST_RC_WITH_PLL || current_source_sel == `OACC_SRC_PRIPLL),
    .pll_locked_in (pll_locked_in),
    .lock_status   (pll_lock_status)
  );

  // Aux divider input follows the source select
  oacc_aux_divider u_div (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .div_code (aux_output_divider),
    .clk_in   (aux_divider_source_sel ? aux_osc_tick : pll_vco_tick), // [R8]
    .clk_out  (div_tick)
  );

  // AHB address phase capture; zero wait state
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= ahb_go && hwrite;
      rd_pend   <= ahb_go && !hwrite;
      if (ahb_go)
        addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data registered at the address phase, unmapped reads zero
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (ahb_go && !hwrite) begin
      case (haddr)
        `OACC_OFS_OSC:  hrdata <= {16'h0000, osc_word};
        `OACC_OFS_ACLK: hrdata <= {16'h0000, aclk_word};
        `OACC_OFS_PPS0: hrdata <= {16'h0000, pps0};
        `OACC_OFS_PPS1: hrdata <= {16'h0000, pps1};
        `OACC_OFS_STAT: hrdata <= {29'h0, int_status};
        `OACC_OFS_IEN:  hrdata <= {29'h0, int_enable};
        default:        hrdata <= 32'h00000000;
      endcase
    end
  end

  // Unlock sequence: two key writes arm one oscillator control write
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_stage <= 2'h0;
    end else if (do_wr) begin
      if (addr_q == `OACC_OFS_UNLOCK && hwdata[15:0] == `OACC_UNLOCK_KEY1)
        unlock_stage <= 2'h1;
      else if (addr_q == `OACC_OFS_UNLOCK && hwdata[15:0] == `OACC_UNLOCK_KEY2 && unlock_stage == 2'h1)
        unlock_stage <= 2'h2;
      else
        unlock_stage <= 2'h0; // [R13]
    end
  end

  // Control registers held only by power-on reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      por_seen               <= 1'b0;
      requested_source_sel   <= 3'h0;
      switch_freeze_bit      <= 1'b0;
      pin_select_write_guard <= 1'b0;
      aux_pll_enable         <= 1'b0;
      aux_divider_source_sel <= 1'b1;
      aux_output_divider     <= 3'h7;
      aux_reference_sel      <= 1'b0;
      aux_pll_input_sel      <= 1'b0;
      pps0                   <= 16'h0000;
      pps1                   <= 16'h0000;
    end else begin
      // Strap caught once after release
      if (!por_seen) begin
        por_seen             <= 1'b1;
        requested_source_sel <= por_source_sel;
      end
      // sys_reset_n is deliberately ignored here
      if (do_wr && addr_q == `OACC_OFS_OSC && osc_unlocked) begin // [R6]
        if (hwdata[10:8] != `OACC_SRC_RSVD)
          requested_source_sel <= hwdata[10:8];
        switch_freeze_bit      <= hwdata[7] | switch_freeze_bit;
        pin_select_write_guard <= hwdata[6];
      end
      if (do_wr && addr_q == `OACC_OFS_ACLK) begin
        aux_pll_enable         <= hwdata[15]; // [R7]
        aux_divider_source_sel <= hwdata[13];
        aux_output_divider     <= hwdata[10:8]; // [R12]
        aux_reference_sel      <= hwdata[7];
        aux_pll_input_sel      <= hwdata[6];
      end
      if (do_wr && addr_q == `OACC_OFS_PPS0 && !pin_select_write_guard)
        pps0 <= hwdata[15:0] & `OACC_PPS_MASK; // [R3]
      if (do_wr && addr_q == `OACC_OFS_PPS1 && !pin_select_write_guard)
        pps1 <= hwdata[15:0] & `OACC_PPS_MASK; // [R3]
    end
  end

  // Switch sequencer; software must route PLL-to-PLL via plain fast RC
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state              <= ST_IDLE;
      sw_count           <= 8'h00;
      switch_request_bit <= 1'b0;
      current_source_sel <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!por_seen)
            current_source_sel <= por_source_sel;
          if (do_wr && addr_q == `OACC_OFS_OSC && osc_unlocked && hwdata[0] && !freeze_active) begin
            switch_request_bit <= 1'b1; // [R13]
            sw_count           <= 8'h00;
            state              <= ST_SWITCH; // [R5]
          end
        end
        ST_SWITCH: begin
          if (sw_count == `OACC_SWITCH_CYC - 1) begin
            current_source_sel <= requested_source_sel; // [R1]
            switch_request_bit <= 1'b0; // [R13]
            state              <= ST_IDLE;
          end else begin
            sw_count <= sw_count + 8'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign ev = {pll_lock_status && !pll_lock_q, clock_fail_in,
               state == ST_SWITCH && sw_count == `OACC_SWITCH_CYC - 1};
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      int_status      <= 3'h0;
      int_enable      <= 3'h0;
      pll_lock_q      <= 1'b0;
      clock_fail_flag <= 1'b0;
      irq             <= 1'b0;
    end else begin
      pll_lock_q <= pll_lock_status;
      if (do_wr && addr_q == `OACC_OFS_IEN)
        int_enable <= hwdata[2:0];
      if (do_wr && addr_q == `OACC_OFS_ICLR)
        int_status <= (int_status & ~hwdata[2:0]) | ev;
      else
        int_status <= int_status | ev;
      if (clock_fail_in)
        clock_fail_flag <= 1'b1;
      else if (do_wr && addr_q == `OACC_OFS_OSC && osc_unlocked && !hwdata[3])
        clock_fail_flag <= 1'b0;
      irq <= |(int_status & int_enable);
    end
  end

  // Registered clock-tree controls
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aux_pll_ref_primary <= 1'b0;
      aux_pll_ref_fast_rc <= 1'b0;
      aux_ref_primary     <= 1'b0;
      aux_clk_tick        <= 1'b0;
      pin_map             <= 32'h00000000;
    end else begin
      aux_ref_primary     <= aux_reference_sel; // [R10]
      aux_pll_ref_fast_rc <= aux_pll_input_sel; // [R11]
      aux_pll_ref_primary <= !aux_pll_input_sel && aux_reference_sel; // [R11]
      aux_clk_tick        <= div_tick;
      pin_map             <= {pps1, pps0};
    end
  end
endmodule
`default_nettype wire
